// file: core/eep_pkg.sv
// Purpose : shared constants and types of the serial eeprom slave core
// Assumes : one 250 MHz core clock samples the two-wire bus pins
// Notes   : device type code is a parameter default, value arbitrary
package eep_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ   = 250;
  localparam int unsigned T_WR_MS   = 5;
  localparam int unsigned WR_CYCLES = T_WR_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // geometry and codes
  // ----------------------------------------------------------------
  localparam int unsigned MAX_AW     = 11;
  localparam int unsigned ADDR_W_DEF = 11;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned PAGE_LSB   = 4;
  localparam int unsigned STRAP_W    = 3;
  localparam logic [3:0]  BIT_ACK    = 4'h8;
  localparam logic [7:0]  ERASED     = 8'hff;
  // arbitrary value, not any maker's device type code
  localparam logic [3:0]  DEV_TYPE_DEF = 4'h5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DEV    = 3'b001,
    ST_WORD   = 3'b011,
    ST_WDATA  = 3'b010,
    ST_RDATA  = 3'b110,
    ST_IGNORE = 3'b111
  } eep_state_t;

  typedef struct packed {
    logic               scl;
    logic               sda;
    logic               wp;
    logic [STRAP_W-1:0] strap;
  } eep_pins_t;

endpackage

// file: core/eep_core.sv
// Purpose : two-wire serial eeprom slave: page write, busy polling,
//           write protect, current/random/sequential read
// Assumes : scl, sda, wp and straps are asynchronous pins
// Notes   : memory contents are not touched by arst_n
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RULE1] page write takes one to sixteen bytes
// [RULE2] master appends at most fifteen more bytes
// [RULE3] ack each data byte, bump low nibble only
// [RULE4] beyond sixteen bytes address wraps within page
// [RULE5] write cycle starts at stop, programs only the loaded buffer bytes
// [RULE6] master may poll right after its stop
// [RULE7] busy device leaves its address unacknowledged
// [RULE8] idle device acknowledges its address again
// [RULE9] write protect high blocks every write
// [RULE10] protect sampled on fall before first data
// [RULE11] protected write: no ack, request discarded
// [RULE12] memory starts fully erased, all ones
// [RULE13] read address: ack, send current byte
// [RULE14] nack then stop returns to standby
// [RULE15] random read uses dummy write, repeated start
// [RULE16] read after dummy write sends loaded location
// [RULE17] master ends random read with nack, stop
// [RULE18] master ack fetches next location
// [RULE19] sequential read wraps at array end only
// [RULE20] smallest array read count does not wrap
// [RULE21] address: type code, straps or high bits, direction
// [RULE22] ack drives data low on ninth clock
// [RULE23] busy device releases data, ignores master
// [RULE24] sample on rising edge, drive on falling
// [RULE25] write cycle length is a counter parameter
module eep_core
  import eep_pkg::*;
#(
  parameter int unsigned ADDR_W    = ADDR_W_DEF,
  parameter int unsigned WR_CYCLES_P = WR_CYCLES,
  parameter logic [3:0]  DEV_TYPE  = DEV_TYPE_DEF
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic ce,
  // two-wire bus, open drain data
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // straps and protection
  input  wire logic wp_i,
  input  wire logic strap_select_bit2,
  input  wire logic strap_select_bit1,
  input  wire logic strap_select_bit0,
  // status
  output logic      write_busy
);

  // ----------------------------------------------------------------
  // derived sizes
  // ----------------------------------------------------------------
  // below 256 bytes the counter keeps eight bits and aliases the array
  localparam int unsigned PTR_W = (ADDR_W < 8) ? 8 : ADDR_W;
  localparam int unsigned HI_W  = PTR_W - 8;
  localparam logic [MAX_AW-1:0] PTR_MASK = MAX_AW'((1 << PTR_W) - 1);
  localparam int unsigned CNT_W = $clog2(WR_CYCLES_P + 1);
  localparam int unsigned DEPTH = 1 << ADDR_W;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  eep_pins_t pins_w;
  eep_pins_t s1_q;
  eep_pins_t s2_q;
  eep_pins_t s3_q;

  assign pins_w = '{scl: scl_i, sda: sda_i, wp: wp_i,
                    strap: {strap_select_bit2, strap_select_bit1, strap_select_bit0}};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, strap: '0};
      s2_q <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, strap: '0};
      s3_q <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, strap: '0};
    end else if (ce) begin
      s1_q <= pins_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  logic rise_w;
  logic fall_w;
  logic start_w;
  logic stop_w;

  assign rise_w  = ce & s2_q.scl & ~s3_q.scl;
  assign fall_w  = ce & ~s2_q.scl & s3_q.scl;
  assign start_w = ce & s2_q.scl & s3_q.scl & s3_q.sda & ~s2_q.sda;
  assign stop_w  = ce & s2_q.scl & s3_q.scl & ~s3_q.sda & s2_q.sda;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  eep_state_t         st_q;
  eep_state_t         st_d;
  logic [3:0]         bit_q;
  logic               ack_q;
  logic               acked_q;
  logic               rw_q;
  logic               mack_q;
  logic               first_q;
  logic               wp_lat_q;
  logic [7:0]         rx_q;
  logic [7:0]         tx_q;
  logic [MAX_AW-1:0]  ptr_q;
  logic [MAX_AW-1:0]  ptr_d;
  logic               sda_oe_q;
  logic               sda_oe_d;
  logic               busy_q;
  logic [CNT_W-1:0]   wr_cnt_q;
  logic [PAGE_BYTES-1:0] vld_q;
  logic [7:0]         buf_q [PAGE_BYTES];
  logic [7:0]         mem_q [DEPTH];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [STRAP_W-1:0] strap_ok;
  logic               dev_hit_w;
  logic               byte_end_w;
  logic               ack_end_w;
  logic               ack_dec_w;
  logic               wr_byte_w;
  logic               tx_load_w;
  logic               commit_w;
  logic               cyc_start_w;
  logic [7:0]         rd_data_w;
  logic [MAX_AW-1:0]  hi_w;
  logic [MAX_AW-1:0]  word_ptr_w;
  logic [MAX_AW-1:0]  ptr_inc_w;

  // bits that are memory address lines skip the strap compare
  for (genvar gi = 0; gi < STRAP_W; gi++) begin : g_strap
    assign strap_ok[gi] = (gi < HI_W) || (rx_q[gi+1] == s2_q.strap[gi]); // see [RULE21]
  end

  assign dev_hit_w  = (rx_q[7:4] == DEV_TYPE) && (&strap_ok); // see [RULE21]
  assign byte_end_w = fall_w && (bit_q == BIT_ACK) && !ack_q;
  assign ack_end_w  = fall_w && ack_q;
  assign ack_dec_w  = byte_end_w &&
                      ((st_q == ST_DEV && dev_hit_w && !busy_q) || // see [RULE7] [RULE8]
                       (st_q == ST_WORD) ||
                       (st_q == ST_WDATA && !(first_q && wp_lat_q))); // see [RULE9] [RULE11]
  assign wr_byte_w  = byte_end_w && (st_q == ST_WDATA) && ack_dec_w;
  assign tx_load_w  = ack_end_w && ((st_q == ST_DEV && acked_q && rw_q) || // see [RULE13]
                                    (st_q == ST_RDATA && mack_q)); // see [RULE18]
  assign cyc_start_w = stop_w && (st_q == ST_WDATA) && (|vld_q); // see [RULE5]
  assign commit_w   = ce && busy_q && (wr_cnt_q == CNT_W'(1));

  assign rd_data_w  = mem_q[ptr_q[ADDR_W-1:0]];
  assign hi_w       = {rx_q[3:1], 8'h00} & PTR_MASK;
  assign word_ptr_w = {ptr_q[MAX_AW-1:8], rx_q} & PTR_MASK;
  assign ptr_inc_w  = (ptr_q + MAX_AW'(1)) & PTR_MASK; // see [RULE19] [RULE20]

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (stop_w) begin
      st_d = ST_IDLE; // see [RULE14]
    end else if (start_w) begin
      st_d = ST_DEV;
    end else if (ack_end_w) begin
      unique case (st_q)
        ST_DEV:   st_d = !acked_q ? ST_IGNORE : (rw_q ? ST_RDATA : ST_WORD); // see [RULE23]
        ST_WORD:  st_d = ST_WDATA;
        ST_WDATA: st_d = acked_q ? ST_WDATA : ST_IGNORE;
        ST_RDATA: st_d = mack_q ? ST_RDATA : ST_IGNORE; // see [RULE14]
        default:  st_d = ST_IGNORE;
      endcase
    end
  end

  always_comb begin
    ptr_d = ptr_q;
    if (byte_end_w && st_q == ST_DEV && dev_hit_w && !busy_q) begin
      ptr_d = (ptr_q & ~(MAX_AW'(11'h700))) | hi_w;
    end else if (byte_end_w && st_q == ST_WORD) begin
      ptr_d = word_ptr_w; // see [RULE15] [RULE16]
    end else if (wr_byte_w) begin
      ptr_d = {ptr_q[MAX_AW-1:PAGE_LSB], ptr_q[PAGE_LSB-1:0] + 4'h1}; // see [RULE3] [RULE4]
    end else if (tx_load_w) begin
      ptr_d = ptr_inc_w; // see [RULE18]
    end
  end

  always_comb begin
    sda_oe_d = sda_oe_q;
    if (start_w || stop_w) begin
      sda_oe_d = 1'b0;
    end else if (byte_end_w) begin
      sda_oe_d = ack_dec_w; // see [RULE22]
    end else if (ack_end_w) begin
      sda_oe_d = tx_load_w ? ~rd_data_w[7] : 1'b0; // see [RULE13]
    end else if (fall_w && st_q == ST_RDATA && bit_q != 4'h0) begin
      sda_oe_d = ~tx_q[6]; // see [RULE24]
    end
  end

  // ----------------------------------------------------------------
  // bit engine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q     <= ST_IDLE;
      bit_q    <= 4'h0;
      ack_q    <= 1'b0;
      acked_q  <= 1'b0;
      rw_q     <= 1'b0;
      mack_q   <= 1'b0;
      rx_q     <= 8'h00;
      ptr_q    <= '0;
      sda_oe_q <= 1'b0;
    end else if (ce) begin
      st_q     <= st_d;
      ptr_q    <= ptr_d;
      sda_oe_q <= sda_oe_d;
      if (start_w || stop_w) begin
        bit_q <= 4'h0;
        ack_q <= 1'b0;
      end else if (rise_w && !ack_q && bit_q != BIT_ACK) begin
        rx_q  <= {rx_q[6:0], s2_q.sda}; // see [RULE24]
        bit_q <= bit_q + 4'h1;
      end else if (rise_w && ack_q) begin
        mack_q <= ~s2_q.sda;
      end else if (byte_end_w) begin
        ack_q   <= 1'b1;
        acked_q <= ack_dec_w;
        if (st_q == ST_DEV) begin
          rw_q <= rx_q[0];
        end
      end else if (ack_end_w) begin
        ack_q <= 1'b0;
        bit_q <= 4'h0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_q <= 8'h00;
    end else if (tx_load_w) begin
      tx_q <= rd_data_w;
    end else if (fall_w && st_q == ST_RDATA && bit_q != 4'h0 && !ack_q) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // protect level is taken on the fall that closes the word address ack
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wp_lat_q <= 1'b0;
      first_q  <= 1'b0;
    end else if (ack_end_w && st_q == ST_WORD) begin
      wp_lat_q <= s2_q.wp; // see [RULE10]
      first_q  <= 1'b1;
    end else if (wr_byte_w) begin
      first_q  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // page buffer
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < PAGE_BYTES; gi++) begin : g_page
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        vld_q[gi] <= 1'b0;
        buf_q[gi] <= ERASED;
      end else if (byte_end_w && st_q == ST_WORD) begin
        vld_q[gi] <= 1'b0;
      end else if (wr_byte_w && ptr_q[PAGE_LSB-1:0] == 4'(gi)) begin
        vld_q[gi] <= 1'b1; // see [RULE1]
        buf_q[gi] <= rx_q; // see [RULE4]
      end else if (commit_w) begin
        vld_q[gi] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // internal write cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q   <= 1'b0;
      wr_cnt_q <= '0;
    end else if (ce) begin
      if (cyc_start_w && !busy_q) begin
        busy_q   <= 1'b1;
        wr_cnt_q <= CNT_W'(WR_CYCLES_P); // see [RULE25]
      end else if (commit_w) begin
        busy_q   <= 1'b0; // see [RULE8]
      end else if (busy_q) begin
        wr_cnt_q <= wr_cnt_q - CNT_W'(1);
      end
    end
  end

  // delivered state is erased; the array has no reset path
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_q[i] = ERASED; // see [RULE12]
    end
  end

  // plain clocked process: the array is also filled by the erase initialiser
  always @(posedge mclk) begin
    if (commit_w) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (vld_q[i]) begin
          mem_q[{ptr_q[ADDR_W-1:PAGE_LSB], 4'(i)}] <= buf_q[i]; // see [RULE5]
        end
      end
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe     = sda_oe_q;
  assign write_busy = busy_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_busy_quiet: assert property (@(posedge mclk) disable iff (!arst_n) // see [RULE23]
    busy_q |-> !sda_oe_q)
    else $error("data line driven during write cycle");
  a_busy_nack: assert property (@(posedge mclk) disable iff (!arst_n) // see [RULE7]
    (byte_end_w && st_q == ST_DEV && busy_q) |=> !sda_oe_q ##1 !acked_q)
    else $error("address acknowledged while busy");
  a_cycle_len: assert property (@(posedge mclk) disable iff (!arst_n) // see [RULE25]
    $rose(busy_q) |-> (wr_cnt_q == CNT_W'(WR_CYCLES_P)) && $past(stop_w))
    else $error("write cycle not started by stop with full count");
  a_cycle_end: assert property (@(posedge mclk) disable iff (!arst_n) // see [RULE8]
    (busy_q && ce && wr_cnt_q == CNT_W'(1)) |=> !busy_q && vld_q == '0)
    else $error("write cycle did not finish on count");
  a_page_wrap: assert property (@(posedge mclk) disable iff (!arst_n) // see [RULE3]
    wr_byte_w |=> ptr_q[MAX_AW-1:PAGE_LSB] == $past(ptr_q[MAX_AW-1:PAGE_LSB]) &&
                  ptr_q[PAGE_LSB-1:0] == $past(ptr_q[PAGE_LSB-1:0]) + 4'h1)
    else $error("write address left its page");
  a_wp_block: assert property (@(posedge mclk) disable iff (!arst_n) // see [RULE11]
    (byte_end_w && st_q == ST_WDATA && first_q && wp_lat_q) |=> !sda_oe_q && vld_q == '0)
    else $error("protected data byte acknowledged");
  a_read_msb: assert property (@(posedge mclk) disable iff (!arst_n) // see [RULE13]
    tx_load_w |=> (sda_oe_q == ~tx_q[7]) && (ptr_q == (($past(ptr_q) + MAX_AW'(1)) & PTR_MASK)))
    else $error("read byte or address step wrong");
  a_ack_drive: assert property (@(posedge mclk) disable iff (!arst_n) // see [RULE22]
    ack_dec_w |=> sda_oe_q && ack_q)
    else $error("acknowledge not driven");
  a_stop_idle: assert property (@(posedge mclk) disable iff (!arst_n) // see [RULE14]
    stop_w |=> st_q == ST_IDLE && !sda_oe_q)
    else $error("stop did not return to standby");

endmodule

`default_nettype wire

// file: sim/eep_bus_master.sv
// Purpose : behavioural two-wire bus master driving the eeprom core
// Assumes : data wire has a pull-up, resolved in the bench
// Notes   : 80 ns bit period, clock idles high between frames
`timescale 1ns/1ps
`default_nettype none
module eep_bus_master (
  // core clock, only to launch frames off an mclk edge
  input  wire logic mclk,
  // bus
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);
  // ----------------------------------------------------------------
  // bus primitives
  // ----------------------------------------------------------------
  localparam time Q = 20ns;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // also a repeated start when the clock is low
  task automatic start();
    @(posedge mclk);
    #1;
    if (!scl) begin
      sda_low = 1'b0;
      #Q scl = 1'b1;
      #Q;
    end
    sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask

  // data set mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    #Q scl = 1'b1;
    #Q s = sda_in;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask

  // last byte is left unacknowledged by the caller
  task automatic rbyte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(!mack, s);
  endtask
endmodule
`default_nettype wire

// file: sim/eep_core_tb.sv
// Purpose : self-checking bench of the eeprom core
// Assumes : short write cycle parameter, pull-up on the data wire
// Notes   : expected memory image is kept here, never read from the core
`timescale 1ns/1ps
`default_nettype none
module eep_core_tb;
  import eep_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam int unsigned WRC = 400;
  localparam logic [3:0]  DT  = DEV_TYPE_DEF;
  logic       mclk, arst_n, wp, scl, m_low, sda_oe, sda_o, busy, k;
  logic [7:0] d;
  logic [7:0] exp_mem [0:2047];
  int         n_errors, samples_checked, cyc;
  wire        sda = (sda_oe ? sda_o : 1'b1) & ~m_low;

  eep_core #(.ADDR_W(11), .WR_CYCLES_P(WRC), .DEV_TYPE(DT)) i_eep_core (
    .mclk(mclk), .arst_n(arst_n), .ce(1'b1), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp), .strap_select_bit2(1'b1),
    .strap_select_bit1(1'b0), .strap_select_bit0(1'b1), .write_busy(busy));
  eep_bus_master i_eep_bus_master (
    .mclk(mclk), .sda_in(sda), .scl(scl), .sda_low(m_low));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // a hung handshake would otherwise run forever
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      $display("ERROR %0t timeout", $time);
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic addr_set(input logic [10:0] a);
    i_eep_bus_master.start();
    i_eep_bus_master.wbyte({DT, a[10:8], 1'b0}, k);
    chk({7'h0, k}, 8'h01, "addr ack");
    i_eep_bus_master.wbyte(a[7:0], k);
    chk({7'h0, k}, 8'h01, "word ack");
  endtask

  // first poll must be refused, a later one accepted
  task automatic poll();
    int n;
    n = 0;
    k = 1'b0;
    while (!k && n < 20) begin
      i_eep_bus_master.start();
      i_eep_bus_master.wbyte({DT, 3'h0, 1'b0}, k);
      i_eep_bus_master.stop();
      n++;
    end
    chk(8'(n > 1), 8'h01, "busy poll nack");
    chk({7'h0, k}, 8'h01, "ready poll ack");
    chk({7'h0, busy}, 8'h00, "busy after poll");
  endtask

  task automatic wr_page(input logic [10:0] a, input int n, input logic [7:0] base);
    logic [3:0] o;
    addr_set(a);
    for (int i = 0; i < n; i++) begin
      o = a[3:0] + i[3:0];
      i_eep_bus_master.wbyte(base + i[7:0], k);
      chk({7'h0, k}, 8'h01, "data ack");
      exp_mem[{a[10:4], o}] = base + i[7:0];
    end
    i_eep_bus_master.stop();
    chk({7'h0, busy}, 8'h01, "busy at stop");
    poll();
  endtask

  task automatic rd_cmp(input logic [10:0] a, input int n);
    logic [10:0] p;
    addr_set(a);
    i_eep_bus_master.start();
    i_eep_bus_master.wbyte({DT, a[10:8], 1'b1}, k);
    chk({7'h0, k}, 8'h01, "read addr ack");
    for (int i = 0; i < n; i++) begin
      p = a + i[10:0];
      i_eep_bus_master.rbyte(i < n - 1, d);
      chk(d, exp_mem[p], "read data");
    end
    i_eep_bus_master.stop();
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_erased();
    rd_cmp(11'h123, 2);
    i_eep_bus_master.start();
    i_eep_bus_master.wbyte({DT ^ 4'h1, 3'h0, 1'b0}, k);
    i_eep_bus_master.stop();
    chk({7'h0, k}, 8'h00, "foreign type");
    $display("test erased done");
  endtask

  // 18 bytes from offset e: two wrap and overwrite the first two
  task automatic t_page();
    wr_page(11'h23e, 18, 8'h40);
    rd_cmp(11'h22f, 18);
    $display("test page done");
  endtask

  task automatic t_wp();
    @(posedge mclk);
    #1 wp = 1'b1;
    addr_set(11'h230);
    i_eep_bus_master.wbyte(8'h99, k);
    i_eep_bus_master.stop();
    chk({7'h0, k}, 8'h00, "protected data");
    chk({7'h0, busy}, 8'h00, "protected busy");
    @(posedge mclk);
    #1 wp = 1'b0;
    rd_cmp(11'h230, 1);
    $display("test protect done");
  endtask

  task automatic t_wrap();
    wr_page(11'h000, 2, 8'ha5);
    rd_cmp(11'h7ff, 2);
    i_eep_bus_master.start();
    i_eep_bus_master.wbyte({DT, 3'h0, 1'b1}, k);
    i_eep_bus_master.rbyte(1'b0, d);
    i_eep_bus_master.stop();
    chk(d, 8'ha6, "current read");
    $display("test wrap done");
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    wp = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    cyc = 0;
    for (int i = 0; i < 2048; i++) begin
      exp_mem[i] = ERASED;
    end
    repeat (8) @(posedge mclk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge mclk);
    t_erased();
    t_page();
    t_wp();
    t_wrap();
    finish_test();
  end
endmodule
`default_nettype wire
